// *** hdl/stream_read_cfg.svh ***
// Offsets, field positions, reset values and timing counts for the stream read decoder.
`ifndef STREAM_READ_CFG_SVH
`define STREAM_READ_CFG_SVH

// ****************************************************************
// Option byte fields
// ****************************************************************
`define OPT_PRIORITY_BIT    7
`define OPT_CONTINUE_BIT    6
`define OPT_NONSEQ_BIT      5
`define OPT_RESUME_BIT      4
`define OPT_STREAM_HI       2
`define OPT_STREAM_LO       0

// ****************************************************************
// Ending status and error fields
// ****************************************************************
`define STAT_OCCUPIED_BIT   7
`define STAT_READY_BIT      6
`define STAT_STREAM_BIT     5
`define STAT_ERR_BIT        0
`define ERR_READ_FAULT_BIT  6
`define ERR_NOT_LOCATED_BIT 4
`define ERR_REJECTED_BIT    2
`define ERR_TIMEOUT_BIT     0
`define STAT_RESET          8'h40
`define ERR_RESET           8'h00

// ****************************************************************
// Timing and sector count limit
// ****************************************************************
`define CLK_PERIOD_NS       50
`define US_NS               1000
`define CYCLES_PER_US       ((`US_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MIN_LIMIT_US        1
`define MAX_SECTORS         17'h10000

`endif

// *** hdl/stream_read_pkg.sv ***
// Types shared by the stream read option decoder.
package stream_read_pkg;

	typedef struct packed {
		logic       priority_transfer_flag;
		logic       continue_on_fault_flag;
		logic       nonsequential_hint;
		logic       resume_recovery_flag;
		logic [2:0] stream_selector;
	} options_t;

	typedef struct packed {
		logic media_read_fault;
		logic sector_not_located;
		logic command_rejected;
	} faults_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_RUN   = 2'b01,
		ST_ABORT = 2'b10
	} phase_t;

endpackage

// *** hdl/limit_resolve.sv ***
// Resolves the completion time limit for one command into microseconds.
`timescale 1ns/1ps
`include "stream_read_cfg.svh"

module limit_resolve #(
	parameter int UNIT_W = 16,
	parameter int LIM_W  = 24
) (
	input  wire logic [7:0]        multiplier,
	input  wire logic [UNIT_W-1:0] time_unit,
	input  wire logic [7:0]        stream_default,
	input  wire logic              default_valid,
	output logic                   limit_enable,
	output logic [LIM_W-1:0]       limit_us
);

	logic [7:0]       chosen;
	logic [LIM_W-1:0] product;

	always_comb
	begin
		chosen = (multiplier != 8'h00) ? multiplier : stream_default;
		limit_enable = (chosen != 8'h00) &&
			((multiplier != 8'h00) || default_valid);
		// Both factors are widened first so the product keeps its upper bits.
		product = LIM_W'(chosen) * LIM_W'(time_unit);
		if (product < LIM_W'(`MIN_LIMIT_US))
			limit_us = LIM_W'(`MIN_LIMIT_US);
		else
			limit_us = product;
	end

endmodule // limit_resolve

// *** hdl/limit_timer.sv ***
// Microsecond countdown of the command completion time limit.
`timescale 1ns/1ps
`include "stream_read_cfg.svh"

module limit_timer #(
	parameter int LIM_W = 24
) (
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic             clk_en,
	input  wire logic             start,
	input  wire logic             stop,
	input  wire logic             enable,
	input  wire logic [LIM_W-1:0] limit_us,
	output logic                  expired
);

	localparam int PRE_W = $clog2(`CYCLES_PER_US + 1);

	typedef struct packed {
		logic             run;
		logic [PRE_W-1:0] pre;
		logic [LIM_W-1:0] left;
		logic             exp;
	} tstate_t;

	tstate_t s_r;
	tstate_t s_nxt;

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.exp = 1'b0;
		if (start)
		begin
			s_nxt.run  = enable;
			s_nxt.pre  = PRE_W'(`CYCLES_PER_US - 1);
			s_nxt.left = limit_us;
		end
		else if (stop)
			s_nxt.run = 1'b0;
		else if (s_r.run)
		begin
			if (s_r.pre != '0)
				s_nxt.pre = s_r.pre - 1'b1;
			else
			begin
				s_nxt.pre = PRE_W'(`CYCLES_PER_US - 1);
				if (s_r.left <= LIM_W'(1))
				begin
					s_nxt.run = 1'b0;
					s_nxt.exp = 1'b1;
				end
				else
					s_nxt.left = s_r.left - 1'b1;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			s_r <= '0;
		else if (clk_en)
			s_r <= s_nxt;
	end

	assign expired = s_r.exp;

endmodule // limit_timer

// *** hdl/stream_read_option_decode.sv ***
// Option decoder and ending status generator for streaming read commands.
`timescale 1ns/1ps
`include "stream_read_cfg.svh"

// Summary of operation
// - Priority flag requests fastest finish; the time limit still ends a priority command.
// - Continue-on-error flag: read or transfer faults never abort the command.
// - Continue mode with faults: full transfer, stream flag set, error clear.
// - Continue mode and timeout: halt, stream flag and timeout log bit set.
// - In continue mode the whole transfer is attempted inside the limit despite bad data.
// - Resume flag: latched per command and shown on resume_active only.
// - Stream selector from option bits 2..0 picks per-stream settings.
// - Limit in microseconds is multiplier byte times identify time unit.
// - Zero multiplier uses the selected stream's stored default limit.
// - Zero or never-configured default means no time limit at all.
// - Timing starts at command write and stops at command completion.
// - A limit below the built-in minimum is raised to the minimum.
// - Stream fault indication sits in status bit 5.
// - Timeout flag bit 0 is set in the error log when the limit runs out, and in the error register outside continue mode.
// - Sector count zero means 65536 sectors; otherwise count as given.
module stream_read_option_decode #(
	parameter int UNIT_W = 16,
	parameter int LIM_W  = 24
) (
	input  wire logic                  clk,
	input  wire logic                  sys_rst,
	input  wire logic                  clk_en,
	input  wire logic [7:0]            stream_read_options,
	input  wire logic [7:0]            completion_limit_multiplier,
	input  wire logic [15:0]           sector_count,
	input  wire logic                  command_write,
	input  wire logic [UNIT_W-1:0]     time_unit,
	input  wire logic                  cfg_write,
	input  wire logic [2:0]            cfg_stream,
	input  wire logic [7:0]            cfg_default,
	input  wire logic                  sector_done,
	input  wire stream_read_pkg::faults_t fault_in,
	output logic                       busy,
	output logic [7:0]                 status_out,
	output logic [7:0]                 error_out,
	output logic [7:0]                 error_log,
	output logic [16:0]                sectors_left,
	output logic [2:0]                 active_stream,
	output logic                       priority_active,
	output logic                       nonseq_active,
	output logic                       resume_active,
	output logic                       done_pulse
);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		stream_read_pkg::phase_t   phase;
		stream_read_pkg::options_t opt;
		logic [16:0]               left;
		logic [7:0]                stat;
		logic [7:0]                err;
		logic [7:0]                log_bits;
		logic                      done;
		logic [7:0]                valid;
	} state_t;

	state_t     s_r;
	state_t     s_nxt;
	logic [7:0] dflt_r [8];

	stream_read_pkg::options_t opt_in;
	logic                      lim_en;
	logic [LIM_W-1:0]          lim_us;
	logic                      expired;
	logic                      finishing;
	logic                      any_fault;

	function automatic logic [16:0] sector_total(input logic [15:0] cnt);
		sector_total = (cnt == 16'h0000) ? `MAX_SECTORS : {1'b0, cnt};
	endfunction

	assign opt_in = stream_read_pkg::options_t'({
		stream_read_options[`OPT_PRIORITY_BIT],
		stream_read_options[`OPT_CONTINUE_BIT],
		stream_read_options[`OPT_NONSEQ_BIT],
		stream_read_options[`OPT_RESUME_BIT],
		stream_read_options[`OPT_STREAM_HI:`OPT_STREAM_LO]});
	assign any_fault = |fault_in;

	// ****************************************************************
	// Per-stream defaults
	// ****************************************************************
	// Defaults are kept apart from the state struct so that they can map
	// onto a small register file without a reset on the data.
	always_ff @(posedge clk)
	begin
		if (clk_en && cfg_write)
			dflt_r[cfg_stream] <= cfg_default;
	end

	limit_resolve #(
		.UNIT_W (UNIT_W),
		.LIM_W  (LIM_W)
	) u_resolve (
		.multiplier     (completion_limit_multiplier),
		.time_unit      (time_unit),
		.stream_default (dflt_r[opt_in.stream_selector]),
		.default_valid  (s_r.valid[opt_in.stream_selector]),
		.limit_enable   (lim_en),
		.limit_us       (lim_us)
	);

	limit_timer #(
		.LIM_W (LIM_W)
	) u_timer (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.clk_en   (clk_en),
		.start    (command_write && s_r.phase == stream_read_pkg::ST_IDLE),
		.stop     (finishing),
		.enable   (lim_en),
		.limit_us (lim_us),
		.expired  (expired)
	);

	// ****************************************************************
	// Command sequencing
	// ****************************************************************
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		finishing = 1'b0;
		if (cfg_write)
			s_nxt.valid[cfg_stream] = 1'b1;
		case (s_r.phase)
			stream_read_pkg::ST_IDLE:
			begin
				if (command_write)
				begin
					s_nxt.phase = stream_read_pkg::ST_RUN;
					s_nxt.opt = opt_in;
					s_nxt.left = sector_total(sector_count);
					s_nxt.stat = 8'h00;
					s_nxt.stat[`STAT_OCCUPIED_BIT] = 1'b1;
					s_nxt.err = 8'h00;
					s_nxt.log_bits = 8'h00;
				end
			end
			stream_read_pkg::ST_RUN:
			begin
				if (any_fault)
				begin
					s_nxt.log_bits[`ERR_READ_FAULT_BIT] =
						s_r.log_bits[`ERR_READ_FAULT_BIT] |
						fault_in.media_read_fault;
					s_nxt.log_bits[`ERR_NOT_LOCATED_BIT] =
						s_r.log_bits[`ERR_NOT_LOCATED_BIT] |
						fault_in.sector_not_located;
					s_nxt.log_bits[`ERR_REJECTED_BIT] =
						s_r.log_bits[`ERR_REJECTED_BIT] |
						fault_in.command_rejected;
				end
				if (sector_done && s_r.left != 17'h00000)
					s_nxt.left = s_r.left - 17'h00001;
				if (expired)
				begin
					// Timeout ends the command in either mode; the limit
					// is a hard bound even for priority commands.
					finishing = 1'b1;
					s_nxt.phase = stream_read_pkg::ST_IDLE;
					s_nxt.stat[`STAT_OCCUPIED_BIT] = 1'b0;
					s_nxt.stat[`STAT_READY_BIT] = 1'b1;
					s_nxt.log_bits[`ERR_TIMEOUT_BIT] = 1'b1;
					if (s_r.opt.continue_on_fault_flag)
					begin
						s_nxt.stat[`STAT_STREAM_BIT] = 1'b1;
						s_nxt.stat[`STAT_ERR_BIT] = 1'b0;
					end
					else
					begin
						s_nxt.stat[`STAT_ERR_BIT] = 1'b1;
						s_nxt.err[`ERR_TIMEOUT_BIT] = 1'b1;
					end
					s_nxt.done = 1'b1;
				end
				else if (any_fault && !s_r.opt.continue_on_fault_flag)
					s_nxt.phase = stream_read_pkg::ST_ABORT;
				else if (s_r.left == 17'h00000 ||
					(s_r.left == 17'h00001 && sector_done))
				begin
					finishing = 1'b1;
					s_nxt.phase = stream_read_pkg::ST_IDLE;
					s_nxt.stat[`STAT_OCCUPIED_BIT] = 1'b0;
					s_nxt.stat[`STAT_READY_BIT] = 1'b1;
					s_nxt.stat[`STAT_ERR_BIT] = 1'b0;
					s_nxt.stat[`STAT_STREAM_BIT] =
						s_r.opt.continue_on_fault_flag &&
						(s_nxt.log_bits != 8'h00);
					s_nxt.done = 1'b1;
				end
			end
			stream_read_pkg::ST_ABORT:
			begin
				// Normal mode stops on the first fault and reports it
				// through the error register. Continue mode never comes here.
				finishing = 1'b1;
				s_nxt.phase = stream_read_pkg::ST_IDLE;
				s_nxt.stat[`STAT_OCCUPIED_BIT] = 1'b0;
				s_nxt.stat[`STAT_READY_BIT] = 1'b1;
				s_nxt.stat[`STAT_ERR_BIT] = 1'b1;
				s_nxt.err = s_r.log_bits;
				s_nxt.done = 1'b1;
			end
			default:
				s_nxt.phase = stream_read_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			s_r <= '0;
			s_r.stat <= `STAT_RESET;
			s_r.err <= `ERR_RESET;
		end
		else if (clk_en)
			s_r <= s_nxt;
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	// All outputs are fields of the state register.
	assign busy            = s_r.stat[`STAT_OCCUPIED_BIT];
	assign status_out      = s_r.stat;
	assign error_out       = s_r.err;
	assign error_log       = s_r.log_bits;
	assign sectors_left    = s_r.left;
	assign active_stream   = s_r.opt.stream_selector;
	assign priority_active = s_r.opt.priority_transfer_flag;
	assign nonseq_active   = s_r.opt.nonsequential_hint;
	assign resume_active   = s_r.opt.resume_recovery_flag;
	assign done_pulse      = s_r.done;

	// ****************************************************************
	// Checks
	// ****************************************************************
	sequence s_timeout;
		s_r.phase == stream_read_pkg::ST_RUN && expired;
	endsequence

	property p_cont_timeout;
		@(posedge clk) disable iff (sys_rst)
		(s_timeout and (clk_en && s_r.opt.continue_on_fault_flag)) |=>
		(status_out[`STAT_STREAM_BIT] && !status_out[`STAT_ERR_BIT] &&
		error_log[`ERR_TIMEOUT_BIT] && !busy);
	endproperty
	a_cont_timeout: assert property (p_cont_timeout)
		else $error("Continue mode timeout status wrong.");

	property p_timeout_log;
		@(posedge clk) disable iff (sys_rst)
		(s_timeout and (clk_en)) |=>
		(error_log[`ERR_TIMEOUT_BIT] && done_pulse);
	endproperty
	a_timeout_log: assert property (p_timeout_log)
		else $error("Timeout flag not set on expiry.");

	property p_no_abort;
		@(posedge clk) disable iff (sys_rst)
		s_r.opt.continue_on_fault_flag |-> s_r.phase != stream_read_pkg::ST_ABORT;
	endproperty
	a_no_abort: assert property (p_no_abort)
		else $error("Continue mode command aborted on fault.");

	property p_count_zero;
		@(posedge clk) disable iff (sys_rst)
		(clk_en && command_write && s_r.phase == stream_read_pkg::ST_IDLE &&
		sector_count == 16'h0000) |=> sectors_left == `MAX_SECTORS;
	endproperty
	a_count_zero: assert property (p_count_zero)
		else $error("Zero sector count not taken as maximum.");

	property p_stream_sel;
		@(posedge clk) disable iff (sys_rst)
		(clk_en && command_write && s_r.phase == stream_read_pkg::ST_IDLE) |=>
		(active_stream == $past(stream_read_options[2:0]) && busy);
	endproperty
	a_stream_sel: assert property (p_stream_sel)
		else $error("Stream selector not captured.");

	property p_cont_fault_end;
		@(posedge clk) disable iff (sys_rst)
		(done_pulse && s_r.opt.continue_on_fault_flag &&
		error_log[`ERR_READ_FAULT_BIT]) |->
		(status_out[`STAT_STREAM_BIT] && !status_out[`STAT_ERR_BIT]);
	endproperty
	a_cont_fault_end: assert property (p_cont_fault_end)
		else $error("Continue mode fault ending status wrong.");

	property p_min_limit;
		@(posedge clk) disable iff (sys_rst)
		lim_en |-> lim_us >= LIM_W'(`MIN_LIMIT_US);
	endproperty
	a_min_limit: assert property (p_min_limit)
		else $error("Limit below built-in minimum.");

	property p_zero_default;
		@(posedge clk) disable iff (sys_rst)
		(completion_limit_multiplier == 8'h00 &&
		!s_r.valid[opt_in.stream_selector]) |-> !lim_en;
	endproperty
	a_zero_default: assert property (p_zero_default)
		else $error("Limit applied without a stream default.");

endmodule // stream_read_option_decode

// *** tb/sector_feeder.sv ***
// Datapath stand-in that reports moved sectors and injects faults.
`timescale 1ns/1ps

module sector_feeder (
	input  wire logic                     clk,
	input  wire logic                     busy,
	input  wire logic                     feed,
	input  wire logic [16:0]              sectors_left,
	input  wire logic [16:0]              fault_at,
	input  wire stream_read_pkg::faults_t fault_kind,
	output logic                          sector_done,
	output stream_read_pkg::faults_t      fault_in
);
	// One sector every other cycle, so the device never sees a free ride.
	logic toggle = 1'b0;

	always @(posedge clk)
	begin
		toggle      <= ~toggle;
		sector_done <= feed && busy && toggle && sectors_left != 17'h0;
		fault_in    <= (busy && toggle && sectors_left == fault_at) ?
			fault_kind : '0;
	end
endmodule // sector_feeder

// *** tb/stream_read_option_decode_tb.sv ***
// Self-checking bench for the streaming read option decoder.
`timescale 1ns/1ps
`define CHK(what, exp, got) \
	begin \
		num_checks++; \
		if ((got) !== (exp)) \
		begin \
			n_fail++; \
			$display("mismatch %s expected %h seen %h", what, exp, got); \
		end \
	end

module stream_read_option_decode_tb;
	logic                     clk = 1'b0;
	logic                     sys_rst = 1'b1;
	logic [7:0]               opts = 8'h00;
	logic [7:0]               mult = 8'h00;
	logic [15:0]              count = 16'h0000;
	logic                     command_write = 1'b0;
	logic [15:0]              time_unit = 16'h0001;
	logic                     cfg_write = 1'b0;
	logic [2:0]               cfg_stream = 3'h0;
	logic [7:0]               cfg_default = 8'h00;
	logic                     feed = 1'b1;
	logic                     clk_en = 1'b1;
	logic [16:0]              fault_at = 17'h1ffff;
	stream_read_pkg::faults_t fault_kind = 3'h0;
	logic                     sector_done;
	stream_read_pkg::faults_t fault_in;
	logic                     busy;
	logic [7:0]               status_out;
	logic [7:0]               error_out;
	logic [7:0]               error_log;
	logic [16:0]              sectors_left;
	logic [2:0]               active_stream;
	logic                     priority_active;
	logic                     nonseq_active;
	logic                     resume_active;
	logic                     done_pulse;
	int                       n_fail = 0;
	int                       num_checks = 0;
	int                       cycles = 0;
	int                       n;

	stream_read_option_decode i_dut (
		.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
		.stream_read_options(opts), .completion_limit_multiplier(mult),
		.sector_count(count), .command_write(command_write),
		.time_unit(time_unit), .cfg_write(cfg_write),
		.cfg_stream(cfg_stream), .cfg_default(cfg_default),
		.sector_done(sector_done), .fault_in(fault_in), .busy(busy),
		.status_out(status_out), .error_out(error_out),
		.error_log(error_log), .sectors_left(sectors_left),
		.active_stream(active_stream), .priority_active(priority_active),
		.nonseq_active(nonseq_active), .resume_active(resume_active),
		.done_pulse(done_pulse)
	);

	sector_feeder i_feed (
		.clk(clk), .busy(busy), .feed(feed), .sectors_left(sectors_left),
		.fault_at(fault_at), .fault_kind(fault_kind),
		.sector_done(sector_done), .fault_in(fault_in)
	);

	initial
	begin
		forever #25 clk = ~clk;
	end

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic finish_test();
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic issue(input logic [7:0] o, input logic [7:0] m,
		input logic [15:0] c);
		opts = o;
		mult = m;
		count = c;
		command_write = 1'b1;
		@(negedge clk);
		command_write = 1'b0;
		`CHK("busy", 1'b1, busy)
	endtask

	task automatic wait_done();
		n = 0;
		while (done_pulse !== 1'b1 && n < 2000)
		begin
			@(negedge clk);
			n++;
		end
		`CHK("done", 1'b1, done_pulse)
	endtask

	task automatic set_default(input logic [2:0] s, input logic [7:0] d);
		cfg_stream = s;
		cfg_default = d;
		cfg_write = 1'b1;
		@(negedge clk);
		cfg_write = 1'b0;
		@(negedge clk);
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset();
		`CHK("status", 8'h40, status_out)
		`CHK("error", 8'h00, error_out)
		`CHK("log", 8'h00, error_log)
	endtask

	task automatic t_options();
		issue(8'hb5, 8'hff, 16'h0002);
		`CHK("stream", 3'h5, active_stream)
		`CHK("prio", 1'b1, priority_active)
		`CHK("nonseq", 1'b1, nonseq_active)
		`CHK("resume", 1'b1, resume_active)
		// A second write while busy must leave the latched options alone.
		@(negedge clk);
		issue(8'h03, 8'h00, 16'h0009);
		`CHK("stream kept", 3'h5, active_stream)
		wait_done();
		`CHK("fast", 1'b1, n < 50)
		`CHK("status", 8'h40, status_out)
		`CHK("left", 17'h0, sectors_left)
	endtask

	task automatic t_faults();
		fault_at = 17'h2;
		fault_kind = 3'b100;
		issue(8'h41, 8'hff, 16'h0004);
		wait_done();
		`CHK("left", 17'h0, sectors_left)
		`CHK("status", 8'h60, status_out)
		`CHK("error", 8'h00, error_out)
		`CHK("log", 8'h40, error_log)
		fault_at = 17'h3;
		fault_kind = 3'b010;
		@(negedge clk);
		issue(8'h02, 8'hff, 16'h0005);
		wait_done();
		`CHK("status", 8'h41, status_out)
		`CHK("error", 8'h10, error_out)
		fault_at = 17'h1ffff;
	endtask

	task automatic t_timeouts();
		feed = 1'b0;
		issue(8'h40, 8'h01, 16'h0008);
		wait_done();
		`CHK("1us", 1'b1, n >= 18 && n <= 24)
		`CHK("status", 8'h60, status_out)
		`CHK("log", 8'h01, error_log)
		`CHK("error", 8'h00, error_out)
		time_unit = 16'h0000;
		issue(8'h00, 8'h05, 16'h0008);
		wait_done();
		`CHK("min", 1'b1, n >= 18 && n <= 24)
		`CHK("status", 8'h41, status_out)
		`CHK("error", 8'h01, error_out)
		time_unit = 16'h0001;
		set_default(3'h2, 8'h04);
		set_default(3'h3, 8'h02);
		set_default(3'h4, 8'h00);
		issue(8'h03, 8'h00, 16'h0008);
		wait_done();
		`CHK("default", 1'b1, n >= 38 && n <= 44)
	endtask

	task automatic t_no_limit();
		for (int s = 4; s <= 6; s += 2)
		begin
			feed = 1'b0;
			issue(s[7:0], 8'h00, 16'h0003);
			repeat (200) @(negedge clk);
			`CHK("no limit", 1'b1, busy)
			feed = 1'b1;
			wait_done();
			`CHK("status", 8'h40, status_out)
		end
	endtask

	task automatic t_max();
		feed = 1'b0;
		issue(8'h40, 8'h01, 16'h0000);
		`CHK("max", 17'h10000, sectors_left)
		// Clock enable low must hold the timer, so the 1 us limit waits.
		clk_en = 1'b0;
		repeat (40) @(negedge clk);
		`CHK("frozen", 1'b1, busy)
		clk_en = 1'b1;
		wait_done();
		`CHK("log", 8'h01, error_log)
	endtask

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_fail++;
			finish_test();
		end
	end

	initial
	begin
		repeat (16) @(negedge clk);
		sys_rst = 1'b0;
		t_reset();
		t_options();
		t_faults();
		t_timeouts();
		t_no_limit();
		t_max();
		finish_test();
	end
endmodule // stream_read_option_decode_tb
